// *** kds_map.svh ***
// constants of the keypad and display serial port: offsets, fields, timing counts
// assumes a 20 MHz ref_clk_i in both ends; included by bare name
// How it works
// - four-wire dout idles high, low on key
// - read command puts key bit six out
// - remaining six bits on falling shift clock
// - dout returns high after seven bits
// - read key decoded from upper nibble only
// - pulse mode gives short low dout pulse
// - load low width free, rising edge counts
// - two-wire bits travel msb first
// - sample while scl high, change while low
// - address bit taken from address pin
// - start is sda falling with scl high
// - frame: 0, 1, address, nibble, rw, ack, byte
// - rw zero writes byte, one reads byte
// - host releases sda during ack slot
// - ack driven only after ack enable command
// - key bits seven to zero driven on sda
// - open-drain interrupt low on key, cleared by read
// - pulse mode waits idle bus, pulses sda
// - transfer may end without stop condition
// - scl shared while sda stays steady
// - shift twelve bits lsb first, load latches
// - key code: column, row, pressed, input bit
`ifndef KDS_MAP_SVH
`define KDS_MAP_SVH
`define KDS_CLK_MHZ 20
`define KDS_CLK_NS 50
`define KDS_CMD_KEY 4'h7
`define KDS_CMD_SYS 4'h4
`define KDS_SYS_IRQ_PULSE_MODE_BIT 5
`define KDS_SYS_KEYB 1
`define KDS_ADDR_FIX0 1'b0
`define KDS_ADDR_FIX1 1'b1
`define KDS_RD_FILL 8'hFF
`define KDS_IDLE_US 40
`define KDS_IDLE_CYC (`KDS_IDLE_US * `KDS_CLK_MHZ + 1)
`define KDS_PULSE_US 4
`define KDS_PULSE_CYC (`KDS_PULSE_US * `KDS_CLK_MHZ)
`define KDS_HALF_NS 1600
`define KDS_HALF_CYC (`KDS_HALF_NS / `KDS_CLK_NS)
`define KDS_TW_BITS 5'h11
`define KDS_FW_BITS 5'h0C
`define KDS_FW_RD_BITS 5'h04
`define KDS_TW_DATA_IDX 5'h09
`define KDS_PIN_DIN 0
`define KDS_PIN_SHIFT_CLOCK_PIN 1
`define KDS_PIN_LOAD 2
`define KDS_PIN_SCL 3
`define KDS_PIN_SDA 4
`define KDS_PIN_ADDR 5
`define KDS_HP_DOUT 0
`define KDS_HP_SDA 1
`define KDS_HP_INT 2
`endif

// *** kds_pkg.sv ***
// types shared by both ends of the keypad and display serial port
// assumes nothing of its surroundings
package kds_pkg;
	typedef logic [7:0]  kds_key_type;
	typedef logic [11:0] kds_cmd_type;
	typedef enum logic [2:0] {
		TW_IDLE = 3'b000,
		TW_HEAD = 3'b001,
		TW_ACKW = 3'b010,
		TW_ACK  = 3'b011,
		TW_WR   = 3'b100,
		TW_RD   = 3'b101
	} kds_tw_state_type;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_START = 3'b001,
		H_BITS  = 3'b010,
		H_LOAD  = 3'b011,
		H_KEY   = 3'b100,
		H_END   = 3'b101
	} kds_host_state_type;
endpackage

// *** kds_if.sv ***
// pins between controller and device, open-drain lines resolved here
// assumes the bench joins one host and one device to one instance
`timescale 1ns/1ps
interface kds_if;
	logic din;
	logic shift_clock_pin;
	logic load;
	logic dout;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic int_oe;
	logic sda;
	logic int_n;
	assign sda   = !(sda_host_oe | sda_dev_oe);
	assign int_n = !int_oe;
	modport host (output din, shift_clock_pin, load, scl, sda_host_oe, input dout, sda, int_n);
	modport dev  (input din, shift_clock_pin, load, scl, sda, output dout, sda_dev_oe, int_oe);
endinterface

// *** kds_buf.sv ***
// small valid/ready buffer held in flip-flops
// assumes both sides on ref_clk_i
`timescale 1ns/1ps
module kds_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;
	assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem_reg[rd_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wr_reg] = in_data_i;
			wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_next = cnt_reg - (AW+1)'(1);
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// *** kds_dev.sv ***
// device end: four-wire and two-wire command port with key read and interrupt
// assumes pins arrive asynchronously; two_wire_i and user inputs on ref_clk_i
`timescale 1ns/1ps
`include "kds_map.svh"
module kds_dev (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_i,
	kds_if.dev                        bus,
	input  wire logic                 two_wire_i,
	input  wire logic                 addr_pin_i,
	input  wire logic                 key_event_i,
	input  wire kds_pkg::kds_key_type keycode_i,
	output kds_pkg::kds_cmd_type      cmd_o,
	output logic                      cmd_stb_o,
	output logic                      keyscan_o,
	output logic                      pulse_mode_o,
	output logic                      ack_en_o,
	output logic                      irq_pend_o
);
	import kds_pkg::*;
	logic [5:0]       pins, s1_reg, s2_reg, s3_reg, flt_reg, flt_next, prv_reg, rise, fall;
	logic [11:0]      shreg_reg, shreg_next;
	logic [6:0]       kout_reg, kout_next;
	logic [2:0]       kcnt_reg, kcnt_next, bcnt_reg, bcnt_next;
	logic             kact_reg, kact_next, dout_reg, dout_next;
	logic             keyscan_reg, keyscan_next, pmode_reg, pmode_next;
	logic             acken_reg, acken_next, irq_reg, irq_next;
	logic             wait_reg, wait_next, oe_reg, oe_next;
	logic             drv_reg, drv_next, int_reg, int_next, stb_reg, stb_next;
	logic [7:0]       key_reg, key_next, hdr_reg, hdr_next, dat_reg, dat_next;
	logic [7:0]       pcnt_reg, pcnt_next;
	logic [9:0]       icnt_reg, icnt_next;
	kds_cmd_type      cmd_reg, cmd_next, exec_cmd;
	logic             exec_v, exec_rd, scl_h;
	kds_tw_state_type st_reg, st_next;

	assign pins = {addr_pin_i, bus.sda, bus.scl, bus.load, bus.shift_clock_pin, bus.din};
	assign rise = flt_reg & ~prv_reg;
	assign fall = ~flt_reg & prv_reg;
	assign scl_h = flt_reg[`KDS_PIN_SCL];
	// a level counts once the second and third stages agree
	assign flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg  <= 6'h3F;
			s2_reg  <= 6'h3F;
			s3_reg  <= 6'h3F;
			flt_reg <= 6'h3F;
			prv_reg <= 6'h3F;
		end else begin
			s1_reg  <= pins;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			flt_reg <= flt_next;
			prv_reg <= flt_reg;
		end
	end

	always_comb begin
		shreg_next   = shreg_reg;
		kout_next    = kout_reg;
		kcnt_next    = kcnt_reg;
		kact_next    = kact_reg;
		dout_next    = dout_reg;
		keyscan_next = keyscan_reg;
		pmode_next   = pmode_reg;
		acken_next   = acken_reg;
		key_next     = key_reg;
		irq_next     = irq_reg;
		wait_next    = wait_reg;
		icnt_next    = icnt_reg;
		st_next      = st_reg;
		bcnt_next    = bcnt_reg;
		hdr_next     = hdr_reg;
		dat_next     = dat_reg;
		oe_next      = oe_reg;
		cmd_next     = cmd_reg;
		stb_next     = 1'b0;
		exec_v       = 1'b0;
		exec_rd      = 1'b0;
		exec_cmd     = shreg_reg;
		pcnt_next    = (pcnt_reg != 8'h00) ? pcnt_reg - 8'h01 : pcnt_reg;
		if (!two_wire_i) begin
			st_next = TW_IDLE;
			oe_next = 1'b0;
			if (rise[`KDS_PIN_SHIFT_CLOCK_PIN]) begin
				shreg_next = {flt_reg[`KDS_PIN_DIN], shreg_reg[11:1]};
			end
			if (rise[`KDS_PIN_LOAD]) begin
				exec_v  = 1'b1;
				exec_rd = (shreg_reg[11:8] == `KDS_CMD_KEY);
			end
			if (exec_rd && keyscan_reg) begin
				kout_next = key_reg[6:0];
				dout_next = key_reg[6];
				kcnt_next = 3'h6;
				kact_next = 1'b1;
			end else if (kact_reg) begin
				if (fall[`KDS_PIN_SHIFT_CLOCK_PIN]) begin
					if (kcnt_reg != 3'h0) begin
						kout_next = {kout_reg[5:0], 1'b1};
						dout_next = kout_reg[5];
						kcnt_next = kcnt_reg - 3'h1;
					end else begin
						kact_next = 1'b0;
						dout_next = 1'b1;
					end
				end
			end else if (keyscan_reg) begin
				dout_next = pmode_reg ? (pcnt_reg == 8'h00) : !irq_reg;
			end else if (fall[`KDS_PIN_SHIFT_CLOCK_PIN]) begin
				dout_next = shreg_reg[0];
			end
		end else begin
			dout_next = 1'b1;
			kact_next = 1'b0;
			if (scl_h && fall[`KDS_PIN_SDA] && pcnt_reg == 8'h00) begin
				st_next   = TW_HEAD;
				bcnt_next = 3'h0;
				oe_next   = 1'b0;
			end else if (scl_h && rise[`KDS_PIN_SDA]) begin
				st_next = TW_IDLE;
				oe_next = 1'b0;
			end else begin
				case (st_reg)
					TW_IDLE: begin
						st_next = TW_IDLE;
					end
					TW_HEAD: begin
						if (rise[`KDS_PIN_SCL]) begin
							hdr_next  = {hdr_reg[6:0], flt_reg[`KDS_PIN_SDA]};
							bcnt_next = bcnt_reg + 3'h1;
							if (bcnt_reg == 3'h7) begin
								st_next = TW_ACKW;
							end
						end
					end
					TW_ACKW: begin
						if (fall[`KDS_PIN_SCL]) begin
							if (hdr_reg[7:5] == {`KDS_ADDR_FIX0, `KDS_ADDR_FIX1,
									flt_reg[`KDS_PIN_ADDR]}) begin
								oe_next = acken_reg;
								st_next = TW_ACK;
							end else begin
								st_next = TW_IDLE;
							end
						end
					end
					TW_ACK: begin
						if (fall[`KDS_PIN_SCL]) begin
							bcnt_next = 3'h0;
							oe_next   = 1'b0;
							if (hdr_reg[0]) begin
								st_next  = TW_RD;
								dat_next = `KDS_RD_FILL;
								if (hdr_reg[4:1] == `KDS_CMD_KEY) begin
									dat_next = key_reg;
									oe_next  = !key_reg[7];
									exec_v   = 1'b1;
									exec_rd  = 1'b1;
									exec_cmd = {hdr_reg[4:1], 8'h00};
								end
							end else begin
								st_next = TW_WR;
							end
						end
					end
					TW_WR: begin
						if (rise[`KDS_PIN_SCL]) begin
							dat_next  = {dat_reg[6:0], flt_reg[`KDS_PIN_SDA]};
							bcnt_next = bcnt_reg + 3'h1;
							if (bcnt_reg == 3'h7) begin
								exec_v   = 1'b1;
								exec_cmd = {hdr_reg[4:1], dat_reg[6:0], flt_reg[`KDS_PIN_SDA]};
								st_next  = TW_IDLE;
							end
						end
					end
					TW_RD: begin
						if (fall[`KDS_PIN_SCL]) begin
							bcnt_next = bcnt_reg + 3'h1;
							if (bcnt_reg == 3'h7) begin
								oe_next = 1'b0;
								st_next = TW_IDLE;
							end else begin
								dat_next = {dat_reg[6:0], 1'b1};
								oe_next  = !dat_reg[6];
							end
						end
					end
					default: begin
						st_next = TW_IDLE;
					end
				endcase
			end
			if (wait_reg) begin
				if (st_reg == TW_IDLE && flt_reg[`KDS_PIN_SCL] && flt_reg[`KDS_PIN_SDA]) begin
					if (icnt_reg == 10'(`KDS_IDLE_CYC - 1)) begin
						wait_next = 1'b0;
						icnt_next = 10'h000;
						pcnt_next = 8'(`KDS_PULSE_CYC);
					end else begin
						icnt_next = icnt_reg + 10'h001;
					end
				end else begin
					icnt_next = 10'h000;
				end
			end
		end
		if (exec_v) begin
			cmd_next = exec_cmd;
			stb_next = 1'b1;
			if (exec_cmd[11:8] == `KDS_CMD_SYS && !exec_rd) begin
				keyscan_next = exec_cmd[`KDS_SYS_KEYB];
				pmode_next   = exec_cmd[`KDS_SYS_IRQ_PULSE_MODE_BIT];
			end
			if (exec_cmd[11:8] == `KDS_CMD_KEY) begin
				if (exec_rd) begin
					irq_next = 1'b0;
				end else if (two_wire_i) begin
					acken_next = 1'b1;
				end
			end
		end
		if (key_event_i) begin
			key_next = keycode_i;
			if (keyscan_reg) begin
				irq_next = 1'b1;
				if (pmode_reg && two_wire_i) begin
					wait_next = 1'b1;
					icnt_next = 10'h000;
				end else if (pmode_reg) begin
					pcnt_next = 8'(`KDS_PULSE_CYC);
				end
			end
		end
		int_next = two_wire_i & irq_next & !wait_next & (pcnt_next == 8'h00);
		drv_next = oe_next | (two_wire_i & (pcnt_next != 8'h00));
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg_reg   <= 12'h000;
			kout_reg    <= 7'h7F;
			kcnt_reg    <= 3'h0;
			kact_reg    <= 1'b0;
			dout_reg    <= 1'b1;
			keyscan_reg <= 1'b0;
			pmode_reg   <= 1'b0;
			acken_reg   <= 1'b0;
			key_reg     <= 8'h00;
			irq_reg     <= 1'b0;
			wait_reg    <= 1'b0;
			icnt_reg    <= 10'h000;
			pcnt_reg    <= 8'h00;
			st_reg      <= TW_IDLE;
			bcnt_reg    <= 3'h0;
			hdr_reg     <= 8'h00;
			dat_reg     <= 8'h00;
			oe_reg      <= 1'b0;
			drv_reg     <= 1'b0;
			int_reg     <= 1'b0;
			cmd_reg     <= 12'h000;
			stb_reg     <= 1'b0;
		end else begin
			shreg_reg   <= shreg_next;
			kout_reg    <= kout_next;
			kcnt_reg    <= kcnt_next;
			kact_reg    <= kact_next;
			dout_reg    <= dout_next;
			keyscan_reg <= keyscan_next;
			pmode_reg   <= pmode_next;
			acken_reg   <= acken_next;
			key_reg     <= key_next;
			irq_reg     <= irq_next;
			wait_reg    <= wait_next;
			icnt_reg    <= icnt_next;
			pcnt_reg    <= pcnt_next;
			st_reg      <= st_next;
			bcnt_reg    <= bcnt_next;
			hdr_reg     <= hdr_next;
			dat_reg     <= dat_next;
			oe_reg      <= oe_next;
			drv_reg     <= drv_next;
			int_reg     <= int_next;
			cmd_reg     <= cmd_next;
			stb_reg     <= stb_next;
		end
	end

	assign bus.dout       = dout_reg;
	assign bus.sda_dev_oe = drv_reg;
	assign bus.int_oe     = int_reg;
	assign cmd_o          = cmd_reg;
	assign cmd_stb_o      = stb_reg;
	assign keyscan_o      = keyscan_reg;
	assign pulse_mode_o   = pmode_reg;
	assign ack_en_o       = acken_reg;
	assign irq_pend_o     = irq_reg;
endmodule

// *** kds_host.sv ***
// controller end: sends queued commands over either wire set, reads key codes
// assumes device pins arrive asynchronously; user side on ref_clk_i
`timescale 1ns/1ps
`include "kds_map.svh"
module kds_host #(
	parameter int HALF_CYC = `KDS_HALF_CYC
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_i,
	kds_if.host                       bus,
	input  wire logic                 two_wire_i,
	input  wire logic                 addr_sel_i,
	input  wire kds_pkg::kds_cmd_type cmd_i,
	input  wire logic                 cmd_rd_i,
	input  wire logic                 cmd_valid_i,
	output logic                      cmd_ready_o,
	output kds_pkg::kds_key_type      key_o,
	output logic                      key_valid_o,
	output logic                      busy_o,
	output logic                      irq_o
);
	import kds_pkg::*;
	logic [2:0]         pins, s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
	logic [12:0]        bq_data;
	logic               bq_valid, bq_ready, tick;
	logic [5:0]         div_reg, div_next;
	logic [4:0]         idx_reg, idx_next, nb_reg, nb_next;
	logic [16:0]        frm_reg, frm_next;
	logic [7:0]         ksh_reg, ksh_next, key_reg, key_next;
	logic               ph_reg, ph_next, rd_reg, rd_next, tw_reg, tw_next, smp_reg, smp_next;
	logic               din_reg, din_next, shift_clock_pin_reg, shift_clock_pin_next, load_reg, load_next;
	logic               scl_reg, scl_next, oe_reg, oe_next, kv_reg, kv_next, irq_reg, irq_next;
	kds_host_state_type st_reg, st_next;

	function automatic logic [11:0] rev12(input logic [11:0] v);
		logic [11:0] r;
		r = 12'h000;
		for (int i = 0; i < 12; i++) begin
			r[11-i] = v[i];
		end
		return r;
	endfunction

	kds_buf #(.WIDTH(13), .DEPTH(2)) u_buf (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.in_data_i   ({cmd_rd_i, cmd_i}),
		.in_valid_i  (cmd_valid_i),
		.in_ready_o  (cmd_ready_o),
		.out_data_o  (bq_data),
		.out_valid_o (bq_valid),
		.out_ready_i (bq_ready)
	);

	assign pins     = {bus.int_n, bus.sda, bus.dout};
	assign flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
	assign bq_ready = (st_reg == H_IDLE);
	assign tick     = (div_reg == 6'(HALF_CYC - 1));

	always_comb begin
		div_next  = (st_reg == H_IDLE || tick) ? 6'h00 : div_reg + 6'h01;
		idx_next  = idx_reg;
		nb_next   = nb_reg;
		frm_next  = frm_reg;
		ksh_next  = ksh_reg;
		key_next  = key_reg;
		ph_next   = ph_reg;
		rd_next   = rd_reg;
		tw_next   = tw_reg;
		smp_next  = smp_reg;
		din_next  = din_reg;
		shift_clock_pin_next = shift_clock_pin_reg;
		load_next = load_reg;
		scl_next  = scl_reg;
		oe_next   = oe_reg;
		st_next   = st_reg;
		kv_next   = 1'b0;
		case (st_reg)
			H_IDLE: begin
				{din_next, shift_clock_pin_next, load_next, scl_next, oe_next} = 5'b11110;
				ph_next  = 1'b0;
				idx_next = 5'h00;
				smp_next = 1'b0;
				if (bq_valid) begin
					tw_next = two_wire_i;
					if (two_wire_i) begin
						rd_next  = bq_data[12];
						frm_next = {`KDS_ADDR_FIX0, `KDS_ADDR_FIX1, addr_sel_i, bq_data[11:8],
							bq_data[12], 1'b1, bq_data[12] ? `KDS_RD_FILL : bq_data[7:0]};
						nb_next  = `KDS_TW_BITS;
						st_next  = H_START;
					end else if (bq_data[11:8] == `KDS_CMD_KEY) begin
						rd_next  = 1'b1;
						frm_next = {bq_data[8], bq_data[9], bq_data[10], bq_data[11], 13'h0000};
						nb_next  = `KDS_FW_RD_BITS;
						st_next  = H_BITS;
					end else begin
						rd_next  = 1'b0;
						frm_next = {rev12(bq_data[11:0]), 5'h00};
						nb_next  = `KDS_FW_BITS;
						st_next  = H_BITS;
					end
				end
			end
			H_START: begin
				if (tick && !ph_reg) begin
					oe_next = 1'b1;
					ph_next = 1'b1;
				end else if (tick) begin
					scl_next = 1'b0;
					ph_next  = 1'b0;
					st_next  = H_BITS;
				end
			end
			H_BITS: begin
				if (tick && !ph_reg) begin
					if (smp_reg) begin
						ksh_next = {ksh_reg[6:0], flt_reg[`KDS_HP_SDA]};
					end
					smp_next = 1'b0;
					if (tw_reg) begin
						scl_next = 1'b0;
						oe_next  = !frm_reg[16];
					end else begin
						shift_clock_pin_next = 1'b0;
						din_next  = frm_reg[16];
					end
					ph_next = 1'b1;
				end else if (tick) begin
					scl_next  = tw_reg ? 1'b1 : scl_reg;
					shift_clock_pin_next = 1'b1;
					smp_next  = tw_reg & rd_reg & (idx_reg >= `KDS_TW_DATA_IDX);
					frm_next  = {frm_reg[15:0], 1'b1};
					idx_next  = idx_reg + 5'h01;
					ph_next   = 1'b0;
					if (idx_reg == nb_reg - 5'h01) begin
						st_next = tw_reg ? H_END : H_LOAD;
					end
				end
			end
			H_LOAD: begin
				if (tick && !ph_reg) begin
					load_next = 1'b0;
					ph_next   = 1'b1;
				end else if (tick) begin
					load_next = 1'b1;
					ph_next   = 1'b0;
					idx_next  = 5'h00;
					st_next   = rd_reg ? H_KEY : H_IDLE;
				end
			end
			H_KEY: begin
				if (tick && !ph_reg) begin
					ksh_next  = {ksh_reg[6:0], flt_reg[`KDS_HP_DOUT]};
					shift_clock_pin_next = 1'b0;
					ph_next   = 1'b1;
				end else if (tick) begin
					shift_clock_pin_next = 1'b1;
					ph_next   = 1'b0;
					idx_next  = idx_reg + 5'h01;
					if (idx_reg == 5'h06) begin
						key_next = {1'b0, ksh_reg[6:0]};
						kv_next  = 1'b1;
						st_next  = H_IDLE;
					end
				end
			end
			H_END: begin
				if (tick && !ph_reg) begin
					if (smp_reg) begin
						ksh_next = {ksh_reg[6:0], flt_reg[`KDS_HP_SDA]};
					end
					smp_next = 1'b0;
					scl_next = 1'b0;
					oe_next  = 1'b0;
					ph_next  = 1'b1;
				end else if (tick) begin
					scl_next = 1'b1;
					ph_next  = 1'b0;
					st_next  = H_IDLE;
					if (rd_reg) begin
						key_next = ksh_reg;
						kv_next  = 1'b1;
					end
				end
			end
			default: begin
				st_next = H_IDLE;
			end
		endcase
		irq_next = (st_next == H_IDLE) & (two_wire_i ?
			(!flt_reg[`KDS_HP_INT] | !flt_reg[`KDS_HP_SDA]) : !flt_reg[`KDS_HP_DOUT]);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg   <= 3'h7;
			s2_reg   <= 3'h7;
			s3_reg   <= 3'h7;
			flt_reg  <= 3'h7;
			div_reg  <= 6'h00;
			idx_reg  <= 5'h00;
			nb_reg   <= 5'h00;
			frm_reg  <= 17'h1_FFFF;
			ksh_reg  <= 8'h00;
			key_reg  <= 8'h00;
			ph_reg   <= 1'b0;
			rd_reg   <= 1'b0;
			tw_reg   <= 1'b0;
			smp_reg  <= 1'b0;
			din_reg  <= 1'b1;
			shift_clock_pin_reg <= 1'b1;
			load_reg <= 1'b1;
			scl_reg  <= 1'b1;
			oe_reg   <= 1'b0;
			kv_reg   <= 1'b0;
			irq_reg  <= 1'b0;
			st_reg   <= H_IDLE;
		end else begin
			s1_reg   <= pins;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			flt_reg  <= flt_next;
			div_reg  <= div_next;
			idx_reg  <= idx_next;
			nb_reg   <= nb_next;
			frm_reg  <= frm_next;
			ksh_reg  <= ksh_next;
			key_reg  <= key_next;
			ph_reg   <= ph_next;
			rd_reg   <= rd_next;
			tw_reg   <= tw_next;
			smp_reg  <= smp_next;
			din_reg  <= din_next;
			shift_clock_pin_reg <= shift_clock_pin_next;
			load_reg <= load_next;
			scl_reg  <= scl_next;
			oe_reg   <= oe_next;
			kv_reg   <= kv_next;
			irq_reg  <= irq_next;
			st_reg   <= st_next;
		end
	end

	assign bus.din         = din_reg;
	assign bus.shift_clock_pin        = shift_clock_pin_reg;
	assign bus.load        = load_reg;
	assign bus.scl         = scl_reg;
	assign bus.sda_host_oe = oe_reg;
	assign key_o           = key_reg;
	assign key_valid_o     = kv_reg;
	assign busy_o          = (st_reg != H_IDLE);
	assign irq_o           = irq_reg;
endmodule

// *** kds_checker.sv ***
// pin assertions for the two-wire and four-wire link between host and device
// assumes tb_top instantiates it beside the kds_if instance
`timescale 1ns/1ps
module kds_checker (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic shift_clock_pin,
	input wire logic load,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe
);
	logic       scl_reg, sda_reg, in_frame_reg, in_frame_next, rise, start;
	logic [4:0] bit_cnt_reg, bit_cnt_next;
	logic [9:0] idle_reg, idle_next;
	// frame tracking: start seen, scl rises since start, idle bus time
	always_comb begin
		rise          = scl && !scl_reg;
		start         = scl && scl_reg && sda_reg && !sda;
		in_frame_next = in_frame_reg || start;
		bit_cnt_next  = start ? 5'h00 : bit_cnt_reg + {4'h0, rise && bit_cnt_reg != 5'h1F};
		idle_next     = (scl && sda) ? idle_reg + {9'h000, idle_reg != 10'h3FF} : 10'h000;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
			in_frame_reg <= 1'b0;
			bit_cnt_reg  <= 5'h00;
			idle_reg     <= 10'h000;
		end else begin
			scl_reg      <= scl;
			sda_reg      <= sda;
			in_frame_reg <= in_frame_next;
			bit_cnt_reg  <= bit_cnt_next;
			idle_reg     <= idle_next;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_dev_sda_timing: assert property ($rose(sda_dev_oe) |-> !scl || idle_reg >= 10'h320)
		else $error("device pulled sda with scl high on a busy bus");
	a_dev_after_start: assert property ($rose(sda_dev_oe) && !scl |-> in_frame_reg)
		else $error("device drove sda before any start");
	a_head_bit_zero: assert property ($rose(scl) && bit_cnt_reg == 5'h00 |-> !sda)
		else $error("first frame bit not zero");
	a_head_bit_one: assert property ($rose(scl) && bit_cnt_reg == 5'h01 |-> sda)
		else $error("second frame bit not one");
	a_ack_slot_free: assert property ($rose(scl) && bit_cnt_reg == 5'h08 |-> !sda_host_oe)
		else $error("host drove sda in the ack slot");
	a_host_sda_low: assert property ($fell(sda_host_oe) |-> !scl)
		else $error("host released sda while scl high");
	a_load_shift_clock_pin_high: assert property ($rose(load) |-> shift_clock_pin)
		else $error("load rose while shift clock low");
	a_shift_clock_pin_load_high: assert property ($changed(shift_clock_pin) |-> load)
		else $error("shift clock moved while load low");
endmodule

// *** tb_top.sv ***
// self-checking bench: one host and one device joined through kds_if
// assumes the design files and kds_checker.sv are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
	import kds_pkg::*;
	logic        ref_clk_i = 1'b0, rst_i = 1'b1, two_wire_i = 1'b0, addr_sel_i = 1'b1;
	logic        cmd_rd_i = 1'b0, cmd_valid_i = 1'b0, key_event_i = 1'b0;
	kds_cmd_type cmd_i = 12'h000, cmd_o;
	kds_key_type keycode_i = 8'h00, key_o;
	logic        cmd_ready_o, busy_o, keyscan_o, ack_en_o, irq_pend_o, irq_o, key_valid_o;
	logic        pulse_mode_o, cmd_stb_o, addr_pin = 1'b1;
	int          fail_count = 0, n_compared = 0, cycles = 0, kv_n = 0, stb_n = 0;
	kds_if bus();
	kds_host #(.HALF_CYC(12)) kds_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus),
		.two_wire_i(two_wire_i), .addr_sel_i(addr_sel_i), .cmd_i(cmd_i), .cmd_rd_i(cmd_rd_i),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .key_o(key_o),
		.key_valid_o(key_valid_o), .busy_o(busy_o), .irq_o(irq_o));
	kds_dev kds_dev_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .two_wire_i(two_wire_i),
		.addr_pin_i(addr_pin), .key_event_i(key_event_i), .keycode_i(keycode_i), .cmd_o(cmd_o),
		.cmd_stb_o(cmd_stb_o), .keyscan_o(keyscan_o), .pulse_mode_o(pulse_mode_o),
		.ack_en_o(ack_en_o), .irq_pend_o(irq_pend_o));
	kds_checker kds_checker_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .shift_clock_pin(bus.shift_clock_pin),
		.load(bus.load), .scl(bus.scl), .sda(bus.sda), .sda_host_oe(bus.sda_host_oe),
		.sda_dev_oe(bus.sda_dev_oe));
	always #25 ref_clk_i = !ref_clk_i;
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		kv_n  += key_valid_o;
		stb_n += cmd_stb_o;
		if (cycles == 20000) begin
			fail_count++;
			test_done;
		end
	end
	task automatic do_reset(input logic tw);
		rst_i      <= 1'b1;
		two_wire_i <= tw;
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
	endtask
	task automatic xfer(input kds_cmd_type c, input logic rd);
		int n;
		cmd_i       <= c;
		cmd_rd_i    <= rd;
		cmd_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		for (n = 0; n < 3000 && busy_o; n++) @(posedge ref_clk_i);
		repeat (8) @(posedge ref_clk_i);
	endtask
	task automatic key(input kds_key_type k);
		keycode_i   <= k;
		key_event_i <= 1'b1;
		@(posedge ref_clk_i);
		key_event_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
	endtask
	initial begin
		do_reset(1'b0);
		`CHK("ready", 1'b1, cmd_ready_o)
		xfer(12'h402, 1'b0);
		`CHK("cmd", 12'h402, cmd_o)
		`CHK("scan", 1'b1, keyscan_o)
		`CHK("busy", 1'b0, busy_o)
		key(8'hE3);
		`CHK("dout_irq", 1'b0, bus.dout)
		`CHK("host_irq", 1'b1, irq_o)
		xfer(12'h7A5, 1'b0);
		`CHK("key4", 8'h63, key_o)
		`CHK("dout_idle", 1'b1, bus.dout)
		`CHK("pend", 1'b0, irq_pend_o)
		xfer(12'h422, 1'b0);
		`CHK("pmode4", 1'b1, pulse_mode_o)
		key(8'hC1);
		`CHK("dout_pulse", 1'b0, bus.dout)
		repeat (80) @(posedge ref_clk_i);
		`CHK("dout_pulse_end", 1'b1, bus.dout)
		do_reset(1'b1);
		xfer(12'h402, 1'b0);
		`CHK("cmd2", 12'h402, cmd_o)
		`CHK("scan2", 1'b1, keyscan_o)
		`CHK("ack_off", 1'b0, ack_en_o)
		xfer(12'h700, 1'b0);
		`CHK("ack_on", 1'b1, ack_en_o)
		key(8'hA5);
		`CHK("int_low", 1'b0, bus.int_n)
		xfer(12'h700, 1'b1);
		`CHK("key2", 8'hA5, key_o)
		`CHK("int_high", 1'b1, bus.int_n)
		addr_sel_i <= 1'b0;
		xfer(12'h400, 1'b0);
		`CHK("other_addr", 1'b1, keyscan_o)
		addr_pin <= 1'b0;
		xfer(12'h422, 1'b0);
		`CHK("own_addr", 1'b1, pulse_mode_o)
		key(8'hC1);
		`CHK("int_wait", 1'b1, bus.int_n)
		repeat (900) @(posedge ref_clk_i);
		`CHK("int_pulse", 1'b0, bus.int_n)
		`CHK("host_irq2", 1'b1, irq_o)
		xfer(12'h700, 1'b1);
		`CHK("key3", 8'hC1, key_o)
		`CHK("key_valid", 3, kv_n)
		`CHK("cmd_stb", 8, stb_n)
		test_done;
	end
endmodule
